/* File: include/iecp_pkg.sv */
// Package of constants and carrier types for the interrupt enable clear port.
package iecp_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int IECP_DATA_W = 32;
   localparam int IECP_ADDR_W = 8;

   // -----------------------------------------------------------------
   // Register offsets, relative to the controller base address
   // -----------------------------------------------------------------
   localparam logic [IECP_ADDR_W-1:0] IECP_OFS_MASK_SET = 8'h10;
   localparam logic [IECP_ADDR_W-1:0] IECP_OFS_MASK_CLEAR = 8'h14;

   // -----------------------------------------------------------------
   // Field positions inside the enable mask
   // -----------------------------------------------------------------
   localparam int IECP_BIT_MASTER_IRQ_ENABLE = 31;
   localparam int IECP_BIT_OWNERSHIP_CHANGE = 30;
   localparam int IECP_BIT_ROOT_HUB_CHANGE = 6;
   localparam int IECP_BIT_FRAME_COUNT_OVERFLOW = 5;
   localparam int IECP_BIT_FATAL_SYSTEM_ERROR = 4;
   localparam int IECP_BIT_RESUME_DETECT = 3;
   localparam int IECP_BIT_FRAME_START = 2;
   localparam int IECP_BIT_DONE_LIST_WRITTEN = 1;
   localparam int IECP_BIT_SCHEDULING_OVERRUN = 0;

   // Bits that hold storage; every other bit is reserved
   localparam logic [IECP_DATA_W-1:0] IECP_IMPL_BITS = 32'hc000_007f;
   // Event source bits, the master enable excluded
   localparam logic [IECP_DATA_W-1:0] IECP_SOURCE_BITS = 32'h4000_007f;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [IECP_DATA_W-1:0] IECP_RST_MASK = 32'h0000_0000;
   localparam logic [IECP_DATA_W-1:0] IECP_RST_RDATA = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Carrier types
   // -----------------------------------------------------------------
   // One register access from host software, taken in a single cycle
   typedef struct packed {
      logic valid;
      logic write;
      logic [IECP_ADDR_W-1:0] addr;
      logic [IECP_DATA_W-1:0] wdata;
   } iecp_req_t;

   // Answer to an access, one cycle after it is taken
   typedef struct packed {
      logic ack;
      logic hit;
      logic [IECP_DATA_W-1:0] rdata;
   } iecp_rsp_t;

endpackage : iecp_pkg

/* File: hw/iecp_mask_bit.sv */
// One storage bit of the shared interrupt enable mask.
module iecp_mask_bit
   import iecp_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire logic set_pulse,
   input wire logic clear_pulse,
   output logic value
);

   // -----------------------------------------------------------------
   // Next value
   // -----------------------------------------------------------------
   // Set and clear come from different offsets, so they never meet;
   // clear is still given priority to keep interrupts off if they did
   logic next_value;
   assign next_value = clear_pulse ? 1'b0 :
                       set_pulse ? 1'b1 :
                       value;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   // Both resets bring the bit back to RESET_VALUE
   always_ff @(posedge ref_clk) begin
      if (rst || soft_rst) begin
         value <= RESET_VALUE;
      end else begin
         value <= next_value;
      end
   end

endmodule // iecp_mask_bit

/* File: hw/iecp_enable_port.sv */
// Interrupt enable mask with its set and clear views and the interrupt request.
module iecp_enable_port
   import iecp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire iecp_req_t req,
   output iecp_rsp_t rsp,
   input wire logic [IECP_DATA_W-1:0] interrupt_event_status,
   output logic [IECP_DATA_W-1:0] enable_mask,
   output logic [IECP_DATA_W-1:0] pending_sources,
   output logic irq
);

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   // Only whole-word locations exist, so the decode compares all
   // address bits; an access that lands inside a word is unmapped
   wire sel_set;
   wire sel_clear;
   wire sel_any;
   assign sel_set = req.valid && (req.addr == IECP_OFS_MASK_SET);
   assign sel_clear = req.valid && (req.addr == IECP_OFS_MASK_CLEAR);

   assign sel_any = sel_set || sel_clear;

   // -----------------------------------------------------------------
   // Write strobes per bit
   // -----------------------------------------------------------------
   // A one in the written word picks the bit; a zero leaves it alone.
   // Reserved positions are masked off so they never reach storage.
   wire wr_set;
   wire wr_clear;
   wire [IECP_DATA_W-1:0] set_bits;
   wire [IECP_DATA_W-1:0] clear_bits;
   assign wr_set = sel_set && req.write;
   assign wr_clear = sel_clear && req.write;
   assign set_bits = wr_set ? (req.wdata & IECP_IMPL_BITS) : '0;
   assign clear_bits = wr_clear ? (req.wdata & IECP_IMPL_BITS) : '0;

   // -----------------------------------------------------------------
   // Per-field strobes
   // -----------------------------------------------------------------
   // Every stored field gets a set and a clear strobe of its own, so a
   // slip in a bit position shows up as a wrong name, not a lost bit
   wire set_master;
   wire set_ownership;
   wire set_root_hub;
   wire set_frame_overflow;
   wire set_fatal_error;
   wire set_resume;
   wire set_frame_start;
   wire set_done_list;
   wire set_overrun;
   assign set_master = set_bits[IECP_BIT_MASTER_IRQ_ENABLE];
   assign set_ownership = set_bits[IECP_BIT_OWNERSHIP_CHANGE];
   assign set_root_hub = set_bits[IECP_BIT_ROOT_HUB_CHANGE];
   assign set_frame_overflow = set_bits[IECP_BIT_FRAME_COUNT_OVERFLOW];
   assign set_fatal_error = set_bits[IECP_BIT_FATAL_SYSTEM_ERROR];
   assign set_resume = set_bits[IECP_BIT_RESUME_DETECT];
   assign set_frame_start = set_bits[IECP_BIT_FRAME_START];
   assign set_done_list = set_bits[IECP_BIT_DONE_LIST_WRITTEN];
   assign set_overrun = set_bits[IECP_BIT_SCHEDULING_OVERRUN];

   // Clear strobes; a zero in the written word leaves them low
   wire clear_master;
   wire clear_ownership;
   wire clear_root_hub;
   wire clear_frame_overflow;
   wire clear_fatal_error;
   wire clear_resume;
   wire clear_frame_start;
   wire clear_done_list;
   wire clear_overrun;
   assign clear_master = clear_bits[IECP_BIT_MASTER_IRQ_ENABLE];
   assign clear_ownership = clear_bits[IECP_BIT_OWNERSHIP_CHANGE];
   assign clear_root_hub = clear_bits[IECP_BIT_ROOT_HUB_CHANGE];
   assign clear_frame_overflow = clear_bits[IECP_BIT_FRAME_COUNT_OVERFLOW];
   assign clear_fatal_error = clear_bits[IECP_BIT_FATAL_SYSTEM_ERROR];
   assign clear_resume = clear_bits[IECP_BIT_RESUME_DETECT];
   assign clear_frame_start = clear_bits[IECP_BIT_FRAME_START];
   assign clear_done_list = clear_bits[IECP_BIT_DONE_LIST_WRITTEN];
   assign clear_overrun = clear_bits[IECP_BIT_SCHEDULING_OVERRUN];

   // -----------------------------------------------------------------
   // Mask storage
   // -----------------------------------------------------------------
   // One cell for each implemented position; reserved bits hold no
   // flip-flop at all, which keeps them out of every read and out of
   // the request logic
   logic [IECP_DATA_W-1:0] mask;
   wire master_irq_enable;
   wire ownership_change_event;
   wire root_hub_change_event;
   wire frame_count_overflow_event;
   wire fatal_system_error_event;
   wire resume_detect_event;
   wire frame_start_event;
   wire done_list_written_event;
   wire scheduling_overrun_event;

   // Master enable: clearing it mutes every source at once, even
   // while their own enables stay set
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_MASTER_IRQ_ENABLE])
   ) u_master_irq_enable (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_master),
      .clear_pulse(clear_master),
      .value(master_irq_enable)
   );

   // Ownership change enable; the one source kept in the top half
   // of the word, next to the master
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_OWNERSHIP_CHANGE])
   ) u_ownership_change (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_ownership),
      .clear_pulse(clear_ownership),
      .value(ownership_change_event)
   );

   // Root hub change enable; port events reach software only
   // through this bit
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_ROOT_HUB_CHANGE])
   ) u_root_hub_change (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_root_hub),
      .clear_pulse(clear_root_hub),
      .value(root_hub_change_event)
   );

   // Frame counter overflow enable; software that keeps time across
   // the counter wrap relies on it
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_FRAME_COUNT_OVERFLOW])
   ) u_frame_count_overflow (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_frame_overflow),
      .clear_pulse(clear_frame_overflow),
      .value(frame_count_overflow_event)
   );

   // Fatal system error enable; left off, a stopped controller can
   // only be found by polling
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_FATAL_SYSTEM_ERROR])
   ) u_fatal_system_error (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_fatal_error),
      .clear_pulse(clear_fatal_error),
      .value(fatal_system_error_event)
   );

   // Resume detect enable; the wake-up path of a suspended bus
   // depends on it
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_RESUME_DETECT])
   ) u_resume_detect (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_resume),
      .clear_pulse(clear_resume),
      .value(resume_detect_event)
   );

   // Frame start enable; it fires every frame, so software normally
   // keeps it off to spare the processor
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_FRAME_START])
   ) u_frame_start (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_frame_start),
      .clear_pulse(clear_frame_start),
      .value(frame_start_event)
   );

   // Done list write-back enable; completed transfers are reported
   // through this bit
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_DONE_LIST_WRITTEN])
   ) u_done_list_written (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_done_list),
      .clear_pulse(clear_done_list),
      .value(done_list_written_event)
   );

   // Scheduling overrun enable; an overloaded schedule is flagged
   // through this bit
   iecp_mask_bit #(
      .RESET_VALUE(IECP_RST_MASK[IECP_BIT_SCHEDULING_OVERRUN])
   ) u_scheduling_overrun (
      .ref_clk(ref_clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .set_pulse(set_overrun),
      .clear_pulse(clear_overrun),
      .value(scheduling_overrun_event)
   );

   // -----------------------------------------------------------------
   // Mask assembly
   // -----------------------------------------------------------------
   // Reserved positions are constant zero, so they read back as zero
   // and can never reach the request logic
   assign mask = {master_irq_enable, ownership_change_event, 23'h000000,
                  root_hub_change_event, frame_count_overflow_event,
                  fatal_system_error_event, resume_detect_event,
                  frame_start_event, done_list_written_event,
                  scheduling_overrun_event};

   // Source enables gathered back into their positions
   wire [IECP_DATA_W-1:0] source_enables;
   assign source_enables = {1'b0, ownership_change_event, 23'h000000,
                            root_hub_change_event, frame_count_overflow_event,
                            fatal_system_error_event, resume_detect_event,
                            frame_start_event, done_list_written_event,
                            scheduling_overrun_event};

   // -----------------------------------------------------------------
   // Interrupt request
   // -----------------------------------------------------------------
   // Each status bit meets the enable at the same position; the master
   // enable then gates the whole set. The status bit 31 has no event of
   // its own, so it is dropped by the source mask.
   wire [IECP_DATA_W-1:0] next_pending;
   wire next_irq;
   assign next_pending = interrupt_event_status & source_enables & IECP_SOURCE_BITS;
   assign next_irq = master_irq_enable && (|next_pending);

   // Registered so the host bus sees a clean level without glitches
   // from status bits that change in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst || soft_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // Per-source view; the master is not applied here, so the status
   // logic can still tell which source is waiting while it is off
   always_ff @(posedge ref_clk) begin
      if (rst || soft_rst) begin
         pending_sources <= '0;
      end else begin
         pending_sources <= next_pending;
      end
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   // Both offsets answer with the live mask; there is no second copy
   // that could drift apart from the one the request logic uses
   wire [IECP_DATA_W-1:0] next_rdata;
   assign next_rdata = (sel_any && !req.write) ? mask : IECP_RST_RDATA;

   // -----------------------------------------------------------------
   // Response
   // -----------------------------------------------------------------
   // Every access is answered one cycle later; hit is low for an
   // unmapped address, whose read data is zero and whose write is lost
   logic rsp_ack;
   logic rsp_hit;
   logic [IECP_DATA_W-1:0] rsp_rdata;

   // Acknowledge follows every taken request, mapped or not
   always_ff @(posedge ref_clk) begin
      if (rst || soft_rst) begin
         rsp_ack <= 1'b0;
      end else begin
         rsp_ack <= req.valid;
      end
   end

   // Hit tells software whether the offset exists at all
   always_ff @(posedge ref_clk) begin
      if (rst || soft_rst) begin
         rsp_hit <= 1'b0;
      end else begin
         rsp_hit <= sel_any;
      end
   end

   // Read data stands for one cycle and is zero otherwise
   always_ff @(posedge ref_clk) begin
      if (rst || soft_rst) begin
         rsp_rdata <= IECP_RST_RDATA;
      end else begin
         rsp_rdata <= next_rdata;
      end
   end

   // Gathered into the carrier the bus side expects
   assign rsp = '{ack: rsp_ack, hit: rsp_hit, rdata: rsp_rdata};

   // The mask drives the event logic of the controller directly
   assign enable_mask = mask;

endmodule // iecp_enable_port

/* File: dv/iecp_enable_port_monitor.sv */
// Concurrent checks on the ports of the interrupt enable clear port.
module iecp_enable_port_monitor
   import iecp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire iecp_req_t req,
   input wire iecp_rsp_t rsp,
   input wire logic [IECP_DATA_W-1:0] interrupt_event_status,
   input wire logic [IECP_DATA_W-1:0] enable_mask,
   input wire logic [IECP_DATA_W-1:0] pending_sources,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Soft reset wins over a same-cycle access, so such accesses are skipped
   wire logic go = req.valid && !soft_rst;
   wire logic [IECP_DATA_W-1:0] live = interrupt_event_status & enable_mask & IECP_SOURCE_BITS;
   wire logic master = enable_mask[IECP_BIT_MASTER_IRQ_ENABLE];
   sequence s_wr(a); go && req.write && req.addr == a; endsequence
   sequence s_rd(a); go && !req.write && req.addr == a; endsequence
   property p_clr_one; s_wr(IECP_OFS_MASK_CLEAR) |=> (enable_mask & $past(req.wdata)) == '0;
   endproperty
   property p_clr_zero; s_wr(IECP_OFS_MASK_CLEAR) |=>
      (enable_mask & ~$past(req.wdata)) == ($past(enable_mask) & ~$past(req.wdata)); endproperty
   property p_set; s_wr(IECP_OFS_MASK_SET) |=>
      (enable_mask & $past(req.wdata)) == ($past(req.wdata) & IECP_IMPL_BITS); endproperty
   property p_read; s_rd(IECP_OFS_MASK_CLEAR) |=>
      rsp.ack && rsp.hit && rsp.rdata == $past(enable_mask); endproperty
   property p_unmap; go && req.addr != IECP_OFS_MASK_SET && req.addr != IECP_OFS_MASK_CLEAR
      |=> rsp.ack && !rsp.hit && rsp.rdata == '0 && $stable(enable_mask); endproperty
   property p_rsvd; (enable_mask & ~IECP_IMPL_BITS) == '0; endproperty
   property p_reset; $past(rst) || $past(soft_rst) |-> enable_mask == '0 && !irq; endproperty
   property p_irq; !soft_rst |=> irq == ($past(live) != '0 && $past(master)); endproperty
   property p_pend; !soft_rst |=> pending_sources == $past(live); endproperty
   a_clr_one: assert property (p_clr_one) else $error("clear left a bit set");
   a_clr_zero: assert property (p_clr_zero) else $error("clear moved a zero bit");
   a_set: assert property (p_set) else $error("set view failed");
   a_read: assert property (p_read) else $error("read not live mask");
   a_unmap: assert property (p_unmap) else $error("unmapped access acted");
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   a_reset: assert property (p_reset) else $error("mask not clear after reset");
   a_irq: assert property (p_irq) else $error("irq level wrong");
   a_pend: assert property (p_pend) else $error("pending map wrong");
endmodule // iecp_enable_port_monitor

/* File: dv/iecp_enable_port_bench.sv */
// Self-checking bench for the interrupt enable clear port.
module iecp_enable_port_bench
   import iecp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic soft_rst = 1'b0;
   iecp_req_t req = '0;
   iecp_rsp_t rsp;
   logic [IECP_DATA_W-1:0] status = '0;
   logic [IECP_DATA_W-1:0] mask;
   logic [IECP_DATA_W-1:0] pend;
   logic irq;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [7:0] odd_addr [3] = '{8'h18, 8'h15, 8'h04};
   localparam logic [7:0] SET = IECP_OFS_MASK_SET;
   localparam logic [7:0] CLR = IECP_OFS_MASK_CLEAR;
   always #10 ref_clk = ~ref_clk;
   iecp_enable_port DUT (.ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst), .req(req),
      .rsp(rsp), .interrupt_event_status(status), .enable_mask(mask),
      .pending_sources(pend), .irq(irq));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One access, answer sampled just after the taking edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(posedge ref_clk);
      req <= '0;
      #1;
      chk("ack", 32'h1, {31'h0, rsp.ack});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic hit);
      acc(1'b0, a, 32'h0);
      chk("rdata", exp, rsp.rdata);
      chk("hit", {31'h0, hit}, {31'h0, rsp.hit});
   endtask
   task automatic cyc();
      @(posedge ref_clk);
      #1;
   endtask
   // Hang guard, far above the fewer than two hundred cycles the tests need
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         complete_run();
      end
   end
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      cyc();
      chk("mask", 32'h0, mask);
      rd(CLR, 32'h0, 1'b1);
      $display("test reset done");
      acc(1'b1, SET, 32'hffff_ffff);
      rd(CLR, IECP_IMPL_BITS, 1'b1);
      for (int i = 0; i < 32; i++) begin
         acc(1'b1, SET, 32'hffff_ffff);
         acc(1'b1, CLR, 32'h1 << i);
         chk("mask", IECP_IMPL_BITS & ~(32'h1 << i), mask);
      end
      $display("test clear bits done");
      // Unmapped offsets must neither clear nor answer with data; the
      // clear loop leaves only the master off, so a stray set shows too
      for (int i = 0; i < 3; i++) begin
         acc(1'b1, odd_addr[i], 32'hffff_ffff);
         rd(odd_addr[i], 32'h0, 1'b0);
         chk("mask", IECP_IMPL_BITS & ~(32'h1 << IECP_BIT_MASTER_IRQ_ENABLE), mask);
      end
      $display("test unmapped done");
      acc(1'b1, SET, 32'hffff_ffff);
      @(posedge ref_clk);
      status <= 32'hbfff_ff80;
      cyc();
      chk("irq", 32'h0, {31'h0, irq});
      @(posedge ref_clk);
      status <= 32'h4;
      cyc();
      chk("irq", 32'h1, {31'h0, irq});
      chk("pend", 32'h4, pend);
      acc(1'b1, CLR, 32'h8000_0000);
      cyc();
      chk("irq", 32'h0, {31'h0, irq});
      chk("pend", 32'h4, pend);
      acc(1'b1, CLR, 32'h4);
      acc(1'b1, SET, 32'h8000_0000);
      cyc();
      chk("irq", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      acc(1'b1, SET, 32'hffff_ffff);
      @(posedge ref_clk);
      soft_rst <= 1'b1;
      @(posedge ref_clk);
      soft_rst <= 1'b0;
      #1;
      chk("mask", 32'h0, mask);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test soft reset done");
      complete_run();
   end
endmodule // iecp_enable_port_bench

bind iecp_enable_port iecp_enable_port_monitor u_mon (.ref_clk(ref_clk), .rst(rst),
   .soft_rst(soft_rst), .req(req), .rsp(rsp), .interrupt_event_status(interrupt_event_status),
   .enable_mask(enable_mask), .pending_sources(pending_sources), .irq(irq));
